// ===== core/lhp_pkg.sv
// Package for the display driver host bus port
package lhp_pkg;
    localparam int LHP_DATA_W = 8;
    localparam int LHP_SER_DATA_BIT = 7;
    localparam int LHP_SER_CLK_BIT = 6;
    localparam logic [7:0] LHP_RD_DATA_RST = 8'h00;
    localparam logic [2:0] LHP_BIT_CNT_RST = 3'h0;
    localparam logic [2:0] LHP_BIT_CNT_LAST = 3'h7;

    typedef struct packed {
        logic is_display;
        logic [7:0] data;
    } lhp_word_s;

    typedef enum logic {LHP_IDLE, LHP_ACTIVE} lhp_strobe_e;
endpackage

// ===== core/lhp_skid_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module lhp_skid_buf
    import lhp_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire lhp_word_s i_in_word,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output lhp_word_s o_out_word
);
    lhp_word_s mem_q [2];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] count_q;
    wire push = i_in_valid && o_in_ready;
    wire pop = o_out_valid && i_out_ready;

    assign o_in_ready = (count_q != 2'h2);
    assign o_out_valid = (count_q != 2'h0);
    assign o_out_word = mem_q[rd_ptr_q];

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else begin
            if (push) begin
                mem_q[wr_ptr_q] <= i_in_word;
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end

    property p_no_overflow;
        @(posedge i_clock) disable iff (i_rst) (count_q == 2'h2 && !pop) |=> count_q == 2'h2;
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("Buffer lost its full state");
endmodule
`default_nettype wire

// ===== core/lhp_host_port.sv
// Host bus port: 8080/6800 parallel or two-wire serial input
`timescale 1ns/1ps
`default_nettype none
module lhp_host_port
    import lhp_pkg::*;
#(
    parameter int DATA_W = LHP_DATA_W
)
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_init_low_input_n,
    input wire logic i_chip_select_low_n,
    input wire logic i_chip_select_high,
    input wire logic i_host_bus_style_select,
    input wire logic i_serial_parallel_select,
    input wire logic i_data_command_select,
    input wire logic i_read_strobe,
    input wire logic i_store_strobe,
    input wire logic [7:0] i_host_data_bus,
    output logic [7:0] o_host_data_bus,
    output logic o_host_data_bus_oe,
    input wire logic [7:0] i_read_data,
    output logic o_read_fetch,
    output logic o_word_valid,
    input wire logic i_word_ready,
    output lhp_word_s o_word,
    output logic o_in_init,
    output logic o_overrun
);
    // *****************************************
    // Checks
    // *****************************************
    if (DATA_W != 8) begin : g_bad_width
        $error("Only an 8-bit host bus is supported");
    end

    // *****************************************
    // Decode
    // *****************************************
    wire in_init = !i_init_low_input_n;
    wire selected = !i_chip_select_low_n && i_chip_select_high;
    wire par_mode = i_serial_parallel_select;
    wire style_6800 = i_host_bus_style_select;
    // Strobe active level per style
    wire rd_act_8080 = !i_read_strobe;
    wire wr_act_8080 = !i_store_strobe;
    wire en_6800 = i_read_strobe;
    wire read_act = selected && par_mode && !in_init &&
        (style_6800 ? (en_6800 && i_store_strobe) : rd_act_8080);
    wire write_act = selected && par_mode && !in_init &&
        (style_6800 ? (en_6800 && !i_store_strobe) : wr_act_8080);
    wire ser_data = i_host_data_bus[LHP_SER_DATA_BIT];
    wire ser_clk = i_host_data_bus[LHP_SER_CLK_BIT];

    // *****************************************
    // State
    // *****************************************
    lhp_strobe_e wr_state_q;
    lhp_strobe_e wr_state_d;
    logic rd_act_q;
    logic ser_clk_q;
    logic [2:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic [7:0] rd_data_q;
    logic overrun_q;
    logic in_valid;
    logic in_ready;
    lhp_word_s in_word;
    logic [7:0] wr_byte_q;
    logic wr_dc_q;

    // Write taken at end of strobe, when host data is surely settled
    // Init cutting a strobe must not push a half-taken byte
    wire wr_end = (wr_state_q == LHP_ACTIVE) && !write_act && !in_init;
    wire ser_rise = selected && !par_mode && !in_init && ser_clk && !ser_clk_q;
    wire ser_done = ser_rise && (bit_cnt_q == LHP_BIT_CNT_LAST);

    always_comb begin
        wr_state_d = wr_state_q;
        unique case (wr_state_q)
            LHP_IDLE: begin
                if (write_act) begin
                    wr_state_d = LHP_ACTIVE;
                end
            end
            LHP_ACTIVE: begin
                if (!write_act) begin
                    wr_state_d = LHP_IDLE;
                end
            end
        endcase
    end

    assign in_valid = wr_end || ser_done;
    assign in_word.is_display = ser_done ? i_data_command_select : wr_dc_q;
    assign in_word.data = ser_done ? {shift_q, ser_data} : wr_byte_q;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            wr_state_q <= LHP_IDLE;
            rd_act_q <= 1'b0;
            ser_clk_q <= 1'b0;
            bit_cnt_q <= LHP_BIT_CNT_RST;
            shift_q <= '0;
            rd_data_q <= LHP_RD_DATA_RST;
            overrun_q <= 1'b0;
            wr_byte_q <= '0;
            wr_dc_q <= 1'b0;
        end else begin
            wr_state_q <= in_init ? LHP_IDLE : wr_state_d;
            rd_act_q <= read_act;
            ser_clk_q <= ser_clk;
            if (write_act) begin
                wr_byte_q <= i_host_data_bus;
                wr_dc_q <= i_data_command_select;
            end
            if (in_init || !selected || par_mode) begin
                bit_cnt_q <= LHP_BIT_CNT_RST;
            end else if (ser_rise) begin
                shift_q <= {shift_q[5:0], ser_data};
                bit_cnt_q <= bit_cnt_q + 3'h1;
            end
            if (read_act && !rd_act_q) begin
                rd_data_q <= i_read_data;
            end
            if (in_init) begin
                overrun_q <= 1'b0;
            end else if (in_valid && !in_ready) begin
                overrun_q <= 1'b1;
            end
        end
    end

    // Read data is fetched once per strobe, at its start
    assign o_read_fetch = read_act && !rd_act_q;
    assign o_host_data_bus = rd_data_q;
    // Drive only in the selected read window; combinational for bus release
    assign o_host_data_bus_oe = read_act && rd_act_q;
    assign o_in_init = in_init;
    assign o_overrun = overrun_q;

    lhp_skid_buf u_buf (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_in_valid(in_valid),
        .o_in_ready(in_ready),
        .i_in_word(in_word),
        .o_out_valid(o_word_valid),
        .i_out_ready(i_word_ready),
        .o_out_word(o_word)
    );

    // *****************************************
    // Assertions
    // *****************************************
    property p_hz_unselected;
        @(posedge i_clock) disable iff (i_rst) !selected |-> !o_host_data_bus_oe;
    endproperty
    a_hz_unselected: assert property (p_hz_unselected) else $error("Bus driven while unselected");

    property p_rd_low_8080;
        @(posedge i_clock) disable iff (i_rst)
            (o_host_data_bus_oe && !style_6800) |-> !i_read_strobe;
    endproperty
    a_rd_low_8080: assert property (p_rd_low_8080) else $error("Driven without low read strobe");

    property p_6800_dir;
        @(posedge i_clock) disable iff (i_rst)
            (o_host_data_bus_oe && style_6800) |-> (i_read_strobe && i_store_strobe);
    endproperty
    a_6800_dir: assert property (p_6800_dir) else $error("6800 read without enable and read direction");

    property p_serial_no_read;
        @(posedge i_clock) disable iff (i_rst) !par_mode |-> !o_host_data_bus_oe;
    endproperty
    a_serial_no_read: assert property (p_serial_no_read) else $error("Read in serial mode");

    property p_init_quiet;
        @(posedge i_clock) disable iff (i_rst) in_init |=> (!o_host_data_bus_oe && bit_cnt_q == 3'h0);
    endproperty
    a_init_quiet: assert property (p_init_quiet) else $error("Activity during init");

    property p_init_flag;
        @(posedge i_clock) disable iff (i_rst) o_in_init == !i_init_low_input_n;
    endproperty
    a_init_flag: assert property (p_init_flag) else $error("Init flag wrong");

    sequence s_wr_8080;
        !style_6800 && write_act ##1 !write_act && !in_init;
    endsequence
    property p_wr_push;
        @(posedge i_clock) disable iff (i_rst) s_wr_8080 |-> in_valid && in_word.data == wr_byte_q;
    endproperty
    a_wr_push: assert property (p_wr_push) else $error("8080 write not pushed");

    property p_ser_byte;
        @(posedge i_clock) disable iff (i_rst)
            ser_done |-> in_word.data == {shift_q, ser_data} && in_word.is_display == i_data_command_select;
    endproperty
    a_ser_byte: assert property (p_ser_byte) else $error("Serial byte wrong");

    property p_ser_shift;
        @(posedge i_clock) disable iff (i_rst) ser_rise |=> shift_q[0] == $past(ser_data);
    endproperty
    a_ser_shift: assert property (p_ser_shift) else $error("Serial bit not shifted in");

    property p_par_no_serial;
        @(posedge i_clock) disable iff (i_rst) par_mode |=> bit_cnt_q == 3'h0;
    endproperty
    a_par_no_serial: assert property (p_par_no_serial) else $error("Serial clock used in parallel mode");
endmodule
`default_nettype wire

// ===== verification/lhp_host_model.sv
// Host processor model driving the port's bus pins
`timescale 1ns/1ps
`default_nettype none
module lhp_host_model (
    input wire logic i_clock,
    input wire logic [7:0] i_bus,
    input wire logic i_oe,
    output var logic [1:0] o_sel,
    output var logic o_style,
    output var logic o_ps,
    output var logic o_dc,
    output var logic o_rd,
    output var logic o_st,
    output var logic [7:0] o_bus
);
    initial begin
        o_sel = 2'h2;
        o_style = 1'b0;
        o_ps = 1'b1;
        o_dc = 1'b0;
        o_rd = 1'b1;
        o_st = 1'b1;
        o_bus = 8'h00;
    end
    // Two active cycles, one idle (8080 store strobe: three active, no idle); bus inverted once released
    task automatic par(input logic [1:0] sel, input logic s68, input logic is_rd, input logic dc,
                       input logic [7:0] d, output logic [8:0] seen);
        o_sel = sel;
        o_ps = 1'b1;
        o_style = s68;
        o_dc = dc;
        o_bus = d;
        o_rd = s68 ? 1'b1 : ~is_rd;
        o_st = is_rd;
        @(posedge i_clock) #1;
        seen = {i_oe, i_bus};
        @(posedge i_clock) #1;
        o_rd = ~s68;
        @(posedge i_clock) #1;
        o_sel = 2'h2;
        o_st = 1'b1;
        o_bus = ~d;
        @(posedge i_clock) #1;
    endtask
    // Serial clock low before each bit and for one cycle after the byte, then left at ~d[6] once the bus is inverted
    task automatic ser(input logic dc, input logic [7:0] d);
        o_ps = 1'b0;
        o_sel = 2'h1;
        o_dc = dc;
        for (int i = 7; i >= 0; i--) begin
            o_bus = {d[i], 7'h00};
            @(posedge i_clock) #1;
            o_bus[6] = 1'b1;
            @(posedge i_clock) #1;
        end
        o_bus[6] = 1'b0;
        @(posedge i_clock) #1;
        o_sel = 2'h2;
        o_ps = 1'b1;
        o_bus = ~d;
    endtask
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Testbench for the host bus port
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lhp_pkg::*;
    logic i_clock, i_rst, init_n, word_ready, oe, fetch, valid, in_init, overrun, style, ps, dc, rd, st;
    logic [1:0] sel;
    logic [7:0] read_data, dout, hbus, bus;
    logic [8:0] seen;
    lhp_word_s word;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    assign bus = oe ? dout : hbus;
    lhp_host_model u_host (.i_clock(i_clock), .i_bus(bus), .i_oe(oe), .o_sel(sel), .o_style(style),
        .o_ps(ps), .o_dc(dc), .o_rd(rd), .o_st(st), .o_bus(hbus));
    lhp_host_port u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_init_low_input_n(init_n),
        .i_chip_select_low_n(sel[1]), .i_chip_select_high(sel[0]), .i_host_bus_style_select(style),
        .i_serial_parallel_select(ps), .i_data_command_select(dc), .i_read_strobe(rd), .i_store_strobe(st),
        .i_host_data_bus(bus), .o_host_data_bus(dout), .o_host_data_bus_oe(oe), .i_read_data(read_data),
        .o_read_fetch(fetch), .o_word_valid(valid), .i_word_ready(word_ready), .o_word(word),
        .o_in_init(in_init), .o_overrun(overrun));
    // ************
    // Bench tasks
    // ************
    task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic getw(input logic [8:0] exp);
        int n;
        n = 0;
        while (valid !== 1'b1 && n < 20) begin
            @(posedge i_clock) #1;
            n++;
        end
        chk("word valid", 9'h001, {8'h00, valid});
        chk("word", exp, word);
        // Receiver takes exactly one word per call
        word_ready = 1'b1;
        @(posedge i_clock) #1;
        word_ready = 1'b0;
    endtask
    task automatic idle_chk(input string name);
        repeat (3) @(posedge i_clock) #1;
        chk(name, 9'h000, {valid, oe, 7'h00});
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    // Hang guard, far above the roughly 140 cycles of real work
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            results();
        end
    end
    // ************
    // Tests
    // ************
    initial begin
        i_rst = 1'b1;
        init_n = 1'b1;
        word_ready = 1'b0;
        read_data = 8'h00;
        repeat (20) @(posedge i_clock);
        #1 i_rst = 1'b0;
        @(posedge i_clock) #1;
        u_host.par(2'h1, 1'b0, 1'b0, 1'b0, 8'h3c, seen);
        getw(9'h03c);
        u_host.par(2'h1, 1'b0, 1'b0, 1'b1, 8'hc3, seen);
        getw(9'h1c3);
        read_data = 8'ha5;
        u_host.par(2'h1, 1'b0, 1'b1, 1'b0, 8'h00, seen);
        chk("read", 9'h1a5, seen);
        idle_chk("oe after read");
        $display("test 8080 done");
        for (int k = 0; k < 2; k++) begin
            u_host.par(k ? 2'h0 : 2'h3, 1'b0, 1'b1, 1'b0, 8'h00, seen);
            chk("oe deselected", 9'h000, {seen[8], 8'h00});
            u_host.par(k ? 2'h0 : 2'h3, 1'b0, 1'b0, 1'b0, 8'h11, seen);
            idle_chk("word deselected");
        end
        $display("test select done");
        u_host.par(2'h1, 1'b1, 1'b0, 1'b1, 8'h5a, seen);
        getw(9'h15a);
        read_data = 8'h96;
        u_host.par(2'h1, 1'b1, 1'b1, 1'b0, 8'h00, seen);
        chk("read 6800", 9'h196, seen);
        idle_chk("oe 6800");
        $display("test 6800 done");
        u_host.ser(1'b1, 8'hb4);
        getw(9'h1b4);
        u_host.ser(1'b0, 8'h01);
        getw(9'h001);
        $display("test serial done");
        // Stalled receiver: two words held, third refused
        for (int k = 1; k < 4; k++) u_host.par(2'h1, 1'b0, 1'b0, 1'b1, 8'(k * 17), seen);
        chk("overrun", 9'h001, {8'h00, overrun});
        chk("held word", 9'h111, word);
        getw(9'h111);
        getw(9'h122);
        idle_chk("drained");
        $display("test buffer done");
        init_n = 1'b0;
        u_host.par(2'h1, 1'b0, 1'b0, 1'b0, 8'h77, seen);
        chk("init", 9'h001, {overrun, 7'h00, in_init});
        idle_chk("write in init");
        init_n = 1'b1;
        u_host.par(2'h1, 1'b0, 1'b0, 1'b0, 8'h88, seen);
        getw(9'h088);
        $display("test init done");
        results();
    end
endmodule
`default_nettype wire
